// File: design/fspc_page_buffer.sv
// Temporary page buffer with once-only word loads.
// Assumes the flash array reads it only during a page write.
`timescale 1ns/1ps
`include "fspc_defines.svh"

module fspc_page_buffer (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        clear_in,
    input  wire logic        wr_in,
    input  wire logic [6:0]  wr_addr_in,
    input  wire logic [15:0] wr_data_in,
    input  wire logic [6:0]  rd_addr_in,
    output logic [15:0]      rd_data_out
);
    logic [15:0] mem_q [`FSPC_BUF_DEPTH];
    logic [`FSPC_BUF_DEPTH-1:0] filled_q;
    logic [15:0] rd_q;

    // Per-word fill flag: a word takes data once between clears
    for (genvar i = 0; i < `FSPC_BUF_DEPTH; i++) begin : g_word
        logic hit;
        assign hit = wr_in && (wr_addr_in == 7'(i)) && !filled_q[i];
        always_ff @(posedge clk_in) begin
            if (!rst_b_in || clear_in) begin
                filled_q[i] <= 1'b0;                      // [RULE22]
            end else if (hit) begin
                filled_q[i] <= 1'b1;
            end
            if (hit) begin
                mem_q[i] <= wr_data_in;                   // [RULE21]
            end
        end
    end

    // Unfilled words read as erased flash
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rd_q <= `FSPC_ERASED_WORD;
        end else begin
            rd_q <= filled_q[rd_addr_in] ? mem_q[rd_addr_in] : `FSPC_ERASED_WORD;
        end
    end

    assign rd_data_out = rd_q;
endmodule

// File: design/fspc_top.sv
// Flash self-program sequencer: control register, arming window,
// page buffer, section busy, halt and ready interrupt.
// Assumes CPU strobes, flash array and register port share clk_in.
//
// Function
// [RULE1]: fuse picks application or boot reset vector
// [RULE2]: fuses are read-only inputs, never CPU-written
// [RULE3]: control resets zero, bit five reads zero
// [RULE4]: ready interrupt while enabled and store-enable clear
// [RULE5]: erase/write to READ_WHILE_WRITE_SECTION sets busy, blocks reads
// [RULE6]: re-enable command clears busy once idle
// [RULE7]: word load clears section busy flag
// [RULE8]: re-enable write aborts buffer loading
// [RULE9]: lock command programs lock bits from low data
// [RULE10]: lock bit clears on completion or timeout
// [RULE11]: load instruction returns lock or fuse bits
// [RULE12]: page write copies buffer to pointer page
// [RULE13]: page erase clears pointer page
// [RULE14]: halt CPU during NO_READ_WHILE_WRITE_SECTION erase or write
// [RULE15]: store-enable alone loads data pair to buffer
// [RULE16]: store-enable clears after store or timeout
// [RULE17]: only five low patterns take effect
// [RULE18]: target address latched at operation start
// [RULE19]: upper pointer selects page, lower selects word
// [RULE20]: software erases before writing, same page
// [RULE21]: buffer words load in any order
// [RULE22]: buffer clears on write, re-enable, reset
// [RULE23]: EEPROM write blocks programming and fuse reads
// [RULE24]: windows count from the accepting write cycle
`timescale 1ns/1ps
`include "fspc_defines.svh"

module fspc_top #(
    parameter logic [15:0] BOOT_RESET_ADDR = 16'hF000,
    parameter logic [7:0]  NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 8'hF0
) (
    input  wire logic                   clk_in,
    input  wire logic                   rst_b_in,
    input  wire logic [7:0]             reg_addr_in,
    input  wire logic [7:0]             reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic [7:0]                  reg_rdata_out,
    input  wire fspc_pkg::fspc_cpu_req_t cpu_req_in,
    input  wire logic                   global_irq_en_in,
    input  wire logic                   eeprom_busy_in,
    input  wire logic                   flash_done_in,
    input  wire logic [6:0]             flash_buf_addr_in,
    input  wire logic                   boot_reset_select_fuse_in,
    input  wire logic [7:0]             fuse_low_in,
    input  wire logic [7:0]             fuse_high_in,
    input  wire logic [7:0]             fuse_ext_in,
    input  wire logic [7:0]             lock_bits_in,
    output logic                        flash_start_out,
    output fspc_pkg::fspc_flash_op_t    flash_op_out,
    output logic [15:0]                 flash_buf_data_out,
    output logic                        cpu_halt_out,
    output logic                        rww_read_block_out,
    output logic                        ready_irq_out,
    output logic                        lpm_valid_out,
    output logic [7:0]                  lpm_data_out,
    output logic [15:0]                 reset_vector_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fspc_pkg::fspc_state_t    state_q, state_d;
    fspc_pkg::fspc_flash_op_t op_q, op_d;
    logic [4:0]  cmd_q, cmd_d;
    logic        ie_q, ie_d;
    logic        busy_q, busy_d;
    logic        start_q, start_d;
    logic        halt_q, halt_d;
    logic        irq_q, irq_d;
    logic        lpm_v_q, lpm_v_d;
    logic [7:0]  lpm_q, lpm_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [15:0] vec_q, vec_d;
    logic        tmr_start, tmr_stop;
    logic        store_open, load_open, expire;
    logic        buf_wr, buf_clr;
    logic        ctrl_wr, legal;
    logic [7:0]  ptr_page;
    logic [6:0]  ptr_word;

    // Pointer split for store operations
    assign ptr_page = cpu_req_in.ptr[`FSPC_PAGE_MSB:`FSPC_PAGE_LSB];   // [RULE19]
    assign ptr_word = cpu_req_in.ptr[`FSPC_WORD_MSB:`FSPC_WORD_LSB];   // [RULE15]
    assign ctrl_wr  = reg_wr_in && (reg_addr_in == `FSPC_CTRL_OFFSET);

    // Patterns outside the five legal ones are dropped
    assign legal = (reg_wdata_in[`FSPC_CMD_MSB:0] == `FSPC_CMD_REEN)  ||
                   (reg_wdata_in[`FSPC_CMD_MSB:0] == `FSPC_CMD_LOCK)  ||
                   (reg_wdata_in[`FSPC_CMD_MSB:0] == `FSPC_CMD_WRITE) ||
                   (reg_wdata_in[`FSPC_CMD_MSB:0] == `FSPC_CMD_ERASE) ||
                   (reg_wdata_in[`FSPC_CMD_MSB:0] == `FSPC_CMD_LOAD);   // [RULE17]

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    fspc_window_timer u_timer (
        .clk_in         (clk_in),
        .rst_b_in       (rst_b_in),
        .start_in       (tmr_start),
        .stop_in        (tmr_stop),
        .store_open_out (store_open),
        .load_open_out  (load_open),
        .expire_out     (expire)
    );

    fspc_page_buffer u_buf (
        .clk_in      (clk_in),
        .rst_b_in    (rst_b_in),
        .clear_in    (buf_clr),
        .wr_in       (buf_wr),
        .wr_addr_in  (ptr_word),
        .wr_data_in  (cpu_req_in.data_pair),
        .rd_addr_in  (flash_buf_addr_in),
        .rd_data_out (flash_buf_data_out)
    );

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    // Commands are accepted only when idle, so a write during an
    // erase or write cannot disturb it; the enable bit is always free.
    always_comb begin
        state_d   = state_q;
        op_d      = op_q;
        cmd_d     = cmd_q;
        ie_d      = ie_q;
        busy_d    = busy_q;
        start_d   = 1'b0;
        lpm_v_d   = 1'b0;
        lpm_d     = lpm_q;
        tmr_start = 1'b0;
        tmr_stop  = 1'b0;
        buf_wr    = 1'b0;
        buf_clr   = 1'b0;
        if (ctrl_wr) begin
            ie_d = reg_wdata_in[`FSPC_BIT_IE];
        end
        unique case (state_q)
            fspc_pkg::FSPC_IDLE: begin
                // EEPROM write locks out arming entirely
                if (ctrl_wr && legal && !eeprom_busy_in) begin          // [RULE17] [RULE23]
                    cmd_d     = reg_wdata_in[`FSPC_CMD_MSB:0];
                    state_d   = fspc_pkg::FSPC_ARMED;
                    tmr_start = 1'b1;                                   // [RULE24]
                    if (reg_wdata_in[`FSPC_CMD_MSB:0] == `FSPC_CMD_REEN) begin
                        buf_clr = 1'b1;                                 // [RULE8] [RULE22]
                    end
                end
            end
            fspc_pkg::FSPC_ARMED: begin
                if (cpu_req_in.store && store_open && !eeprom_busy_in) begin
                    tmr_stop = 1'b1;
                    cmd_d    = `FSPC_CMD_NONE;                          // [RULE16]
                    state_d  = fspc_pkg::FSPC_IDLE;
                    unique case (cmd_q)
                        `FSPC_CMD_LOAD: begin
                            buf_wr = 1'b1;                              // [RULE15]
                            busy_d = 1'b0;                              // [RULE7]
                        end
                        `FSPC_CMD_REEN: begin
                            busy_d = 1'b0;                              // [RULE6]
                        end
                        `FSPC_CMD_LOCK: begin
                            // Pointer and high byte play no part here
                            op_d.kind      = fspc_pkg::FSPC_OP_LOCK;    // [RULE9]
                            op_d.page      = 8'h00;
                            op_d.lock_data = `FSPC_LOCK_FILL;
                            op_d.lock_data[`FSPC_LOCK_MSB:`FSPC_LOCK_LSB] =
                                cpu_req_in.data_pair[`FSPC_LOCK_MSB:`FSPC_LOCK_LSB];
                            cmd_d   = cmd_q;
                            start_d = 1'b1;
                            state_d = fspc_pkg::FSPC_BUSY;
                        end
                        `FSPC_CMD_WRITE,
                        `FSPC_CMD_ERASE: begin
                            op_d.kind = (cmd_q == `FSPC_CMD_WRITE) ?
                                        fspc_pkg::FSPC_OP_WRITE :
                                        fspc_pkg::FSPC_OP_ERASE;        // [RULE12] [RULE13]
                            op_d.page      = ptr_page;                  // [RULE18]
                            op_d.lock_data = 8'h00;
                            cmd_d   = cmd_q;                            // [RULE16]
                            start_d = 1'b1;
                            state_d = fspc_pkg::FSPC_BUSY;
                            if (ptr_page < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE) begin
                                busy_d = 1'b1;                          // [RULE5]
                            end
                        end
                        default: begin
                            cmd_d = `FSPC_CMD_NONE;
                        end
                    endcase
                end else if (cpu_req_in.load && load_open && (cmd_q == `FSPC_CMD_LOCK)) begin
                    tmr_stop = 1'b1;
                    cmd_d    = `FSPC_CMD_NONE;                          // [RULE10]
                    state_d  = fspc_pkg::FSPC_IDLE;
                    // Fuse reads are withheld during an EEPROM write
                    if (!eeprom_busy_in) begin                          // [RULE23]
                        lpm_v_d = 1'b1;                                 // [RULE11]
                        unique case (cpu_req_in.ptr[1:0])
                            `FSPC_SEL_FLOW:  lpm_d = fuse_low_in;
                            `FSPC_SEL_LOCK:  lpm_d = lock_bits_in;
                            `FSPC_SEL_FEXT:  lpm_d = fuse_ext_in;
                            `FSPC_SEL_FHIGH: lpm_d = fuse_high_in;
                        endcase
                    end
                end else if (expire) begin
                    cmd_d   = `FSPC_CMD_NONE;                           // [RULE10] [RULE13] [RULE16]
                    state_d = fspc_pkg::FSPC_IDLE;
                end
            end
            fspc_pkg::FSPC_BUSY: begin
                // Store-enable and the command bit stay up until done
                if (flash_done_in) begin
                    cmd_d   = `FSPC_CMD_NONE;                           // [RULE12] [RULE16]
                    state_d = fspc_pkg::FSPC_IDLE;
                    op_d.kind = fspc_pkg::FSPC_OP_NONE;
                    if (op_q.kind == fspc_pkg::FSPC_OP_WRITE) begin
                        buf_clr = 1'b1;                                 // [RULE22]
                    end
                end
            end
            default: begin
                state_d = fspc_pkg::FSPC_IDLE;
                cmd_d   = `FSPC_CMD_NONE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Output next values
    // ------------------------------------------------------------
    always_comb begin
        // CPU halts only for array work inside the NO_READ_WHILE_WRITE_SECTION section
        halt_d = (state_d == fspc_pkg::FSPC_BUSY) &&
                 (op_d.kind != fspc_pkg::FSPC_OP_LOCK) &&
                 (op_d.page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);                        // [RULE14]
        irq_d  = ie_d && global_irq_en_in && !cmd_d[0];                 // [RULE4]
        // Fuses are plain inputs; no path lets the CPU change them
        vec_d  = boot_reset_select_fuse_in ? 16'h0000 : BOOT_RESET_ADDR; // [RULE1] [RULE2]
        rdata_d = 8'h00;
        if (reg_rd_in && (reg_addr_in == `FSPC_CTRL_OFFSET)) begin
            rdata_d = {ie_q, busy_q, 1'b0, cmd_q};                      // [RULE3]
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_q <= fspc_pkg::FSPC_IDLE;
            op_q    <= '0;
            cmd_q   <= `FSPC_CMD_NONE;
            ie_q    <= 1'b0;                                            // [RULE3]
            busy_q  <= 1'b0;
            start_q <= 1'b0;
            halt_q  <= 1'b0;
            irq_q   <= 1'b0;
            lpm_v_q <= 1'b0;
            lpm_q   <= 8'h00;
            rdata_q <= `FSPC_CTRL_RESET;
            vec_q   <= 16'h0000;
        end else begin
            state_q <= state_d;
            op_q    <= op_d;
            cmd_q   <= cmd_d;
            ie_q    <= ie_d;
            busy_q  <= busy_d;
            start_q <= start_d;
            halt_q  <= halt_d;
            irq_q   <= irq_d;
            lpm_v_q <= lpm_v_d;
            lpm_q   <= lpm_d;
            rdata_q <= rdata_d;
            vec_q   <= vec_d;
        end
    end

    assign reg_rdata_out      = rdata_q;
    assign flash_start_out    = start_q;
    assign flash_op_out       = op_q;
    assign cpu_halt_out       = halt_q;
    assign rww_read_block_out = busy_q;                                 // [RULE5]
    assign ready_irq_out      = irq_q;
    assign lpm_valid_out      = lpm_v_q;
    assign lpm_data_out       = lpm_q;
    assign reset_vector_out   = vec_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_reserved_reads_zero: assert property (reg_rdata_out[`FSPC_BIT_RES] == 1'b0) // [RULE3]
        else $error("reserved control bit read as one");

    a_irq_tracks_enable: assert property (
        ready_irq_out == (ie_q && $past(global_irq_en_in) && !cmd_q[0])) // [RULE4]
        else $error("ready interrupt does not follow enable and store-enable");

    a_rww_start_busy: assert property (
        flash_start_out && (flash_op_out.kind != fspc_pkg::FSPC_OP_LOCK) &&
        (flash_op_out.page < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE) |-> rww_read_block_out) // [RULE5]
        else $error("READ_WHILE_WRITE_SECTION operation started without busy flag");

    a_load_clears_busy: assert property (
        (state_q == fspc_pkg::FSPC_ARMED) && (cmd_q == `FSPC_CMD_LOAD) &&
        cpu_req_in.store && store_open && !eeprom_busy_in |=> !rww_read_block_out) // [RULE7]
        else $error("word load left busy flag set");

    a_window_timeout: assert property (
        ctrl_wr && legal && (state_q == fspc_pkg::FSPC_IDLE) && !eeprom_busy_in
        ##1 (!cpu_req_in.store && !cpu_req_in.load) [*4] |=> (cmd_q == `FSPC_CMD_NONE)) // [RULE16]
        else $error("command bits survived an expired window");

    a_enable_held_busy: assert property (
        (state_q == fspc_pkg::FSPC_BUSY) && !flash_done_in |=> cmd_q[0]) // [RULE16]
        else $error("store-enable dropped during array operation");

    a_no_read_while_write_section_halt: assert property (
        flash_start_out && (flash_op_out.kind != fspc_pkg::FSPC_OP_LOCK) &&
        (flash_op_out.page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE) |-> cpu_halt_out) // [RULE14]
        else $error("NO_READ_WHILE_WRITE_SECTION operation started without halting the CPU");

    a_illegal_ignored: assert property (
        ctrl_wr && !legal && (state_q == fspc_pkg::FSPC_IDLE) |=> (cmd_q == `FSPC_CMD_NONE)) // [RULE17]
        else $error("illegal command pattern took effect");

    a_eeprom_blocks: assert property (eeprom_busy_in |=> !flash_start_out && !lpm_valid_out) // [RULE23]
        else $error("programming or fuse read during EEPROM write");

    a_page_latched: assert property (
        (state_q == fspc_pkg::FSPC_BUSY) && $past(state_q == fspc_pkg::FSPC_BUSY) |->
        $stable(flash_op_out.page)) // [RULE18]
        else $error("target page changed during operation");

    a_reset_vector: assert property (
        reset_vector_out == ($past(boot_reset_select_fuse_in) ? 16'h0000 : BOOT_RESET_ADDR)) // [RULE1]
        else $error("reset vector does not match fuse");

    c_word_load: cover property (buf_wr);
    c_erase_start: cover property (flash_start_out && (flash_op_out.kind == fspc_pkg::FSPC_OP_ERASE));
    c_fuse_read: cover property (lpm_valid_out);
    c_timeout: cover property ((state_q == fspc_pkg::FSPC_ARMED) && expire && !cpu_req_in.store);
endmodule

// File: design/fspc_window_timer.sv
// Arming window counter for store and load instructions.
// Assumes start and stop come from logic on the same clock.
`timescale 1ns/1ps
`include "fspc_defines.svh"

module fspc_window_timer (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic start_in,
    input  wire logic stop_in,
    output logic      store_open_out,
    output logic      load_open_out,
    output logic      expire_out
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;

    // Reload on start, clear on stop, count down to zero otherwise
    always_comb begin
        cnt_d = cnt_q;
        if (start_in) begin
            cnt_d = `FSPC_SPM_WINDOW;
        end else if (stop_in) begin
            cnt_d = 3'h0;
        end else if (cnt_q != 3'h0) begin
            cnt_d = cnt_q - 3'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Load window is the first three of the four store cycles
    assign store_open_out = (cnt_q != 3'h0);
    assign load_open_out  = (cnt_q > (`FSPC_SPM_WINDOW - `FSPC_LPM_WINDOW));
    assign expire_out     = (cnt_q == 3'h1);
endmodule

// File: pkg/fspc_defines.svh
// Constants of the flash self-program control block.
// Assumes inclusion by bare name from design files.
`ifndef FSPC_DEFINES_SVH
`define FSPC_DEFINES_SVH

// ------------------------------------------------------------
// Register map and fields
// ------------------------------------------------------------
`define FSPC_CTRL_OFFSET 8'h00
`define FSPC_CTRL_RESET  8'h00
`define FSPC_BIT_IE      7
`define FSPC_BIT_BUSY    6
`define FSPC_BIT_RES     5
`define FSPC_CMD_MSB     4

// ------------------------------------------------------------
// Low-five-bit command patterns: none and the five legal ones
// ------------------------------------------------------------
`define FSPC_CMD_NONE    5'h00
`define FSPC_CMD_REEN    5'h11
`define FSPC_CMD_LOCK    5'h09
`define FSPC_CMD_WRITE   5'h05
`define FSPC_CMD_ERASE   5'h03
`define FSPC_CMD_LOAD    5'h01

// ------------------------------------------------------------
// Windows, pointer layout, buffer, fuse select
// ------------------------------------------------------------
`define FSPC_SPM_WINDOW  3'h4
`define FSPC_LPM_WINDOW  3'h3
`define FSPC_WORD_LSB    1
`define FSPC_WORD_MSB    7
`define FSPC_PAGE_LSB    8
`define FSPC_PAGE_MSB    15
`define FSPC_BUF_DEPTH   128
`define FSPC_ERASED_WORD 16'hFFFF
`define FSPC_SEL_FLOW    2'h0
`define FSPC_SEL_LOCK    2'h1
`define FSPC_SEL_FEXT    2'h2
`define FSPC_SEL_FHIGH   2'h3
`define FSPC_LOCK_LSB    2
`define FSPC_LOCK_MSB    5
`define FSPC_LOCK_FILL   8'hC3

`endif

// File: pkg/fspc_pkg.sv
// Types shared by the flash self-program control block.
// Assumes nothing beyond a SystemVerilog compiler.
package fspc_pkg;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        FSPC_IDLE  = 3'b001,
        FSPC_ARMED = 3'b010,
        FSPC_BUSY  = 3'b100
    } fspc_state_t;

    // Flash array operations
    typedef enum logic [1:0] {
        FSPC_OP_NONE  = 2'h0,
        FSPC_OP_ERASE = 2'h1,
        FSPC_OP_WRITE = 2'h2,
        FSPC_OP_LOCK  = 2'h3
    } fspc_op_t;

    // Instruction strobes from the CPU core
    typedef struct packed {
        logic        store;
        logic        load;
        logic [15:0] ptr;
        logic [15:0] data_pair;
    } fspc_cpu_req_t;

    // Operation handed to the flash array
    typedef struct packed {
        fspc_op_t    kind;
        logic [7:0]  page;
        logic [7:0]  lock_data;
    } fspc_flash_op_t;

endpackage

// File: sim/fspc_far_model.sv
// Flash array stand-in: answers each start with a done pulse.
// Assumes start is a one-cycle pulse on the shared clock.
`timescale 1ns/1ps
module fspc_far_model #(
    parameter int DLY = 8
) (
    input  wire logic clk_in,
    input  wire logic start_in,
    output logic      done_out
);
    int cnt = 0;
    // Done comes DLY cycles after start, never in the start cycle
    always @(posedge clk_in) begin
        done_out <= (cnt == 1);
        if (start_in)
            cnt <= DLY;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the flash self-program sequencer.
// Assumes one 50 MHz clock and the register port of the top.
`timescale 1ns/1ps
module testbench;
    logic clk_in = 1'b0, rst_b_in = 1'b0, wr = 1'b0, rd = 1'b0, bf = 1'b1, ee = 1'b0;
    logic [7:0] wd = 8'h00, lk = 8'h3C, rdat, ld;
    logic [6:0] baddr = 7'h00;
    fspc_pkg::fspc_cpu_req_t cr = '0;
    fspc_pkg::fspc_flash_op_t op;
    logic start, halt, blk, irq, lv, done;
    logic [15:0] bdat, rv;
    int err_count = 0, compares = 0, n;
    // ------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------
    fspc_top i_fspc_top (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(8'h00),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
        .cpu_req_in(cr), .global_irq_en_in(1'b1), .eeprom_busy_in(ee),
        .flash_done_in(done), .flash_buf_addr_in(baddr), .boot_reset_select_fuse_in(bf),
        .fuse_low_in(8'hA5), .fuse_high_in(8'h5A), .fuse_ext_in(8'hFD), .lock_bits_in(lk),
        .flash_start_out(start), .flash_op_out(op), .flash_buf_data_out(bdat),
        .cpu_halt_out(halt), .rww_read_block_out(blk), .ready_irq_out(irq),
        .lpm_valid_out(lv), .lpm_data_out(ld), .reset_vector_out(rv));
    fspc_far_model i_fspc_far_model (.clk_in(clk_in), .start_in(start), .done_out(done));
    // Free-running clock
    initial forever #10 clk_in = ~clk_in;
    task chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wt(input int k);
        repeat (k) @(posedge clk_in);
    endtask
    // One-cycle strobes, changed only just after an edge
    task wreg(input logic [7:0] d);
        @(posedge clk_in) begin wr <= 1'b1; wd <= d; end
        @(posedge clk_in) wr <= 1'b0;
    endtask
    task rreg(input logic [7:0] e);
        @(posedge clk_in) rd <= 1'b1;
        @(posedge clk_in) rd <= 1'b0;
        #1 chk({8'h00, rdat}, {8'h00, e});
    endtask
    // Store (st=1) or load (st=0) instruction pulse
    task store_program_instr(input logic st, input logic [15:0] p, input logic [15:0] d);
        @(posedge clk_in) begin cr.store <= st; cr.load <= !st; cr.ptr <= p; cr.data_pair <= d; end
        @(posedge clk_in) begin cr.store <= 1'b0; cr.load <= 1'b0; end
    endtask
    task end_sim;
        if (err_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence; the erase precedes the write of the same page
    initial begin
        wt(16);
        rst_b_in <= 1'b1;
        wt(2);
        #1 chk(rv, 16'h0000);
        rreg(8'h00);
        wreg(8'hFF);
        rreg(8'h80);
        #1 chk({15'h0000, irq}, 16'h0001);
        wreg(8'h81);
        wt(5);
        rreg(8'h80);
        wreg(8'h83);
        store_program_instr(1'b1, 16'h10FE, 16'h0000);
        #1 chk({6'h00, op.kind, op.page}, {6'h00, fspc_pkg::FSPC_OP_ERASE, 8'h10});
        rreg(8'hC3);
        chk({15'h0000, blk}, 16'h0001);
        wt(10);
        rreg(8'hC0);
        wreg(8'h81);
        store_program_instr(1'b1, 16'h100A, 16'h1234);
        rreg(8'h80);
        @(posedge clk_in) baddr <= 7'h05;
        wt(2);
        #1 chk(bdat, 16'h1234);
        wreg(8'h85);
        store_program_instr(1'b1, 16'h10FE, 16'h0000);
        #1 chk({6'h00, op.kind, op.page}, {6'h00, fspc_pkg::FSPC_OP_WRITE, 8'h10});
        wt(12);
        rreg(8'hC0);
        chk(bdat, 16'hFFFF);
        // Busy is still set here, so the re-enable has work to do
        wreg(8'h91);
        store_program_instr(1'b1, 16'h0000, 16'h0000);
        rreg(8'h80);
        wreg(8'h81);
        store_program_instr(1'b1, 16'h000A, 16'h5678);
        wreg(8'h81);
        store_program_instr(1'b1, 16'h000A, 16'h9ABC);
        wt(2);
        #1 chk(bdat, 16'h5678);
        wreg(8'h91);
        store_program_instr(1'b1, 16'h0000, 16'h0000);
        #1 chk(bdat, 16'hFFFF);
        wreg(8'h89);
        store_program_instr(1'b0, 16'h0001, 16'h0000);
        #1 chk({7'h00, lv, ld}, {8'h01, lk});
        wreg(8'h89);
        store_program_instr(1'b1, 16'h1234, 16'hFF14);
        #1 chk({6'h00, op.kind, op.lock_data}, {6'h00, fspc_pkg::FSPC_OP_LOCK, 8'hD7});
        wt(12);
        rreg(8'h80);
        // A command written during an EEPROM write must not arm
        @(posedge clk_in) ee <= 1'b1;
        wreg(8'h83);
        rreg(8'h80);
        @(posedge clk_in) ee <= 1'b0;
        wreg(8'h83);
        store_program_instr(1'b1, 16'hF000, 16'h0000);
        wt(1);
        #1 chk({15'h0000, halt}, 16'h0001);
        for (n = 0; n < 40 && halt === 1'b1; n++)
            @(posedge clk_in);
        #1 chk({15'h0000, halt}, 16'h0000);
        @(posedge clk_in) bf <= 1'b0;
        wt(2);
        #1 chk(rv, 16'hF000);
        end_sim;
    end
endmodule
